// ==== verilog/emtx_pkg.sv ====
// emtx_pkg: constants, modes and carrier types for the transmit client port
// assumes: one transmit clock, AXI4-Lite register access, byte-wide streams
package emtx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] EMTX_ADDR_CTRL = 4'h0;
  localparam logic [3:0] EMTX_ADDR_IFG = 4'h4;
  localparam logic [3:0] EMTX_ADDR_STATS = 4'h8;
  localparam logic [3:0] EMTX_ADDR_STATUS = 4'hC;

  // control register fields
  localparam int EMTX_CTRL_SPEED_LSB = 0;
  localparam int EMTX_CTRL_HALF_BIT = 2;
  localparam int EMTX_CTRL_AV_BIT = 3;
  localparam logic [31:0] EMTX_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] EMTX_IFG_RESET = 8'h0C;

  // statistics vector fields
  localparam int EMTX_ST_OK_BIT = 0;
  localparam int EMTX_ST_UNDERRUN_BIT = 3;
  localparam int EMTX_ST_LEN_LSB = 5;
  localparam int EMTX_ST_LEN_W = 14;
  localparam int EMTX_ST_LATE_BIT = 22;
  localparam int EMTX_ST_EXCESS_BIT = 23;
  localparam int EMTX_ST_TRY_LSB = 25;
  localparam int EMTX_ST_TRY_W = 4;
  localparam int EMTX_ST_PFC_BIT = 32;
  localparam logic [13:0] EMTX_LEN_MAX = 14'd16368;
  localparam logic [3:0] EMTX_TRY_MAX = 4'hF;

  // pacing: clocks per byte at each speed
  localparam logic [7:0] EMTX_PACE_1G = 8'h01;
  localparam logic [7:0] EMTX_PACE_100M = 8'h0A;
  localparam logic [7:0] EMTX_PACE_10M = 8'h64;

  // line speed codes
  typedef enum logic [1:0] {
    EMTX_SPD_10M = 2'b00,
    EMTX_SPD_100M = 2'b01,
    EMTX_SPD_1G = 2'b10
  } emtx_speed_t;

  // one byte stream
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
    logic error;
  } emtx_stream_t;

  // collision sideband
  typedef struct packed {
    logic collision;
    logic retransmit;
  } emtx_coll_t;

endpackage

// ==== verilog/emtx_client_port.sv ====
// emtx_client_port: transmit client port of a tri-speed ethernet mac
// assumes: one clock aclk, synchronous active-low reset, registers over AXI4-Lite
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module emtx_client_port
  import emtx_pkg::*;
#(
  parameter bit PFC_EN = 1'b0,
  parameter bit AV_EN = 1'b1,
  parameter int ST_W = PFC_EN ? 33 : 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // main byte stream
  input wire logic [7:0] stream_byte_in,
  input wire logic stream_valid_in,
  input wire logic stream_last_in,
  input wire logic stream_error_in,
  output logic stream_ready_out,
  // av byte stream
  input wire logic [7:0] av_stream_byte_in,
  input wire logic av_stream_valid_in,
  input wire logic av_stream_last_in,
  input wire logic av_stream_error_in,
  output logic av_stream_ready_out,
  // sideband
  input wire logic [7:0] ifg_delay_in,
  input wire logic medium_collision_in,
  output logic collision_out,
  output logic retransmit_out,
  output logic [ST_W-1:0] stats_vector_out,
  output logic stats_valid_out,
  // toward the mac engine
  output logic [7:0] phy_byte_out,
  output logic phy_valid_out,
  output logic phy_error_out,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EMTX_IDLE = 3'b001,
    EMTX_SEND = 3'b010,
    EMTX_GAP = 3'b100
  } emtx_state_t;

  emtx_state_t state_reg;
  emtx_stream_t cur;
  emtx_coll_t coll_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] ifg_reg;
  logic [7:0] pace_reg;
  logic [7:0] gap_reg;
  logic [13:0] len_reg;
  logic [3:0] try_reg;
  logic err_reg;
  logic late_reg;
  logic av_sel_reg;
  logic take;
  logic [7:0] pace_len;
  logic half_dup;
  logic av_on;
  logic [1:0] aw_have_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign half_dup = ctrl_reg[EMTX_CTRL_HALF_BIT];
  assign av_on = AV_EN && ctrl_reg[EMTX_CTRL_AV_BIT];

  // pacing period follows the configured speed
  always_comb begin
    unique case (emtx_speed_t'(ctrl_reg[EMTX_CTRL_SPEED_LSB +: 2]))
      EMTX_SPD_10M: pace_len = EMTX_PACE_10M;
      EMTX_SPD_100M: pace_len = EMTX_PACE_100M;
      default: pace_len = EMTX_PACE_1G;
    endcase
  end

  // selected stream, av stream has priority between frames
  always_comb begin
    if (av_sel_reg) begin
      cur = '{av_stream_byte_in, av_stream_valid_in, av_stream_last_in, av_stream_error_in};
    end else begin
      cur = '{stream_byte_in, stream_valid_in, stream_last_in, stream_error_in};
    end
  end

  // a byte moves when valid meets the registered ready
  // no byte of an aborted frame reaches the engine once the collision is reported
  assign take = cur.valid && (av_sel_reg ? av_stream_ready_out : stream_ready_out) && !coll_reg.collision;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= EMTX_IDLE;
      av_sel_reg <= 1'b0;
      gap_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        EMTX_IDLE: begin
          if (av_on && av_stream_valid_in) begin
            av_sel_reg <= 1'b1;
            state_reg <= EMTX_SEND;
          end else if (stream_valid_in) begin
            av_sel_reg <= 1'b0;
            state_reg <= EMTX_SEND;
          end
        end
        EMTX_SEND: begin
          if (coll_reg.collision) begin
            state_reg <= EMTX_IDLE;
          end else if (take && cur.last) begin
            gap_reg <= ifg_reg;
            state_reg <= (ifg_reg == 8'h00) ? EMTX_IDLE : EMTX_GAP;
          end
        end
        EMTX_GAP: begin
          gap_reg <= gap_reg - 8'h01;
          if (gap_reg == 8'h01) begin
            state_reg <= EMTX_IDLE;
          end
        end
      endcase
    end
  end

  // ready pacing: ready is a one-cycle pulse once per byte period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace_reg <= 8'h00;
      stream_ready_out <= 1'b0;
      av_stream_ready_out <= 1'b0;
    end else begin
      stream_ready_out <= 1'b0;
      av_stream_ready_out <= 1'b0;
      // the period counter runs through take cycles so spacing equals the pace count
      if (state_reg == EMTX_SEND && !coll_reg.collision && !(take && cur.last)) begin
        if (pace_reg == 8'h00) begin
          pace_reg <= pace_len - 8'h01;
          stream_ready_out <= !av_sel_reg;
          av_stream_ready_out <= av_sel_reg;
        end else begin
          pace_reg <= pace_reg - 8'h01;
        end
      end else begin
        pace_reg <= 8'h00;
      end
    end
  end

  // bytes toward the engine, error follows the user flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_byte_out <= 8'h00;
      phy_valid_out <= 1'b0;
      phy_error_out <= 1'b0;
    end else begin
      phy_valid_out <= take;
      if (take) begin
        phy_byte_out <= cur.data;
      end
      phy_error_out <= take && cur.error;
    end
  end

  // collision reporting, silent in full duplex
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coll_reg <= '0;
      try_reg <= 4'h0;
      late_reg <= 1'b0;
    end else begin
      coll_reg <= '0;
      if (half_dup && state_reg == EMTX_SEND && medium_collision_in && !coll_reg.collision) begin
        coll_reg.collision <= 1'b1;
        coll_reg.retransmit <= (try_reg != EMTX_TRY_MAX);
        late_reg <= (len_reg > 14'd64);
        if (try_reg != EMTX_TRY_MAX) begin
          try_reg <= try_reg + 4'h1;
        end
      end else if (stats_valid_out) begin
        try_reg <= 4'h0;
        late_reg <= 1'b0;
      end
    end
  end
  assign collision_out = coll_reg.collision;
  assign retransmit_out = coll_reg.retransmit;

  // length and error collection for the statistics
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_reg <= 14'h0000;
      err_reg <= 1'b0;
    end else if (coll_reg.collision || stats_valid_out) begin
      len_reg <= 14'h0000;
      err_reg <= 1'b0;
    end else if (take) begin
      if (len_reg != EMTX_LEN_MAX) begin
        len_reg <= len_reg + 14'h0001;
      end
      err_reg <= err_reg | cur.error;
    end
  end

  // statistics vector and its valid pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stats_vector_out <= '0;
      stats_valid_out <= 1'b0;
    end else begin
      stats_valid_out <= 1'b0;
      if (state_reg == EMTX_SEND && take && cur.last) begin
        stats_valid_out <= 1'b1;
        stats_vector_out <= '0;
        stats_vector_out[EMTX_ST_OK_BIT] <= !(err_reg | cur.error);
        stats_vector_out[EMTX_ST_UNDERRUN_BIT] <= err_reg | cur.error;
        stats_vector_out[EMTX_ST_LEN_LSB +: EMTX_ST_LEN_W] <=
          (len_reg == EMTX_LEN_MAX) ? EMTX_LEN_MAX : len_reg + 14'h0001;
        stats_vector_out[EMTX_ST_TRY_LSB +: EMTX_ST_TRY_W] <= try_reg;
        stats_vector_out[EMTX_ST_LATE_BIT] <= late_reg;
        stats_vector_out[EMTX_ST_EXCESS_BIT] <= (try_reg == EMTX_TRY_MAX);
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // write path: address and data taken in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 2'b00;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_reg <= EMTX_CTRL_RESET;
      ifg_reg <= EMTX_IFG_RESET;
    end else begin
      s_axi_awready <= !aw_have_reg[0] && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !aw_have_reg[1] && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg[0] <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        aw_have_reg[1] <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_have_reg == 2'b11 && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        aw_have_reg <= 2'b00;
        if (awaddr_reg[3:2] == EMTX_ADDR_CTRL[3:2] && wstrb_reg[0]) begin
          ctrl_reg[7:0] <= wdata_reg[7:0];
        end else if (awaddr_reg[3:2] == EMTX_ADDR_IFG[3:2] && wstrb_reg[0]) begin
          ifg_reg <= wdata_reg[7:0];
        end else if (awaddr_reg[3:2] != EMTX_ADDR_CTRL[3:2] && awaddr_reg[3:2] != EMTX_ADDR_IFG[3:2]) begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // gap port overrides the register whenever it is nonzero
      if (ifg_delay_in != 8'h00) begin
        ifg_reg <= ifg_delay_in;
      end
    end
  end

  // read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        unique case (s_axi_araddr[3:2])
          EMTX_ADDR_CTRL[3:2]: s_axi_rdata <= ctrl_reg;
          EMTX_ADDR_IFG[3:2]: s_axi_rdata <= {24'h00_0000, ifg_reg};
          EMTX_ADDR_STATS[3:2]: s_axi_rdata <= stats_vector_out[31:0];
          default: s_axi_rdata <= {29'h0000_0000, state_reg};
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_full_duplex_quiet;
    @(posedge aclk) disable iff (!aresetn) !half_dup |=> !collision_out && !retransmit_out;
  endproperty
  a_full_duplex_quiet: assert property (p_full_duplex_quiet) else $error("collision in full duplex");

  property p_stats_after_last;
    @(posedge aclk) disable iff (!aresetn) (state_reg == EMTX_SEND && take && cur.last) |=> stats_valid_out;
  endproperty
  a_stats_after_last: assert property (p_stats_after_last) else $error("no stats pulse after last");

  property p_stats_pulse;
    @(posedge aclk) disable iff (!aresetn) stats_valid_out |=> !stats_valid_out;
  endproperty
  a_stats_pulse: assert property (p_stats_pulse) else $error("stats valid longer than one cycle");

  property p_ok_bit;
    @(posedge aclk) disable iff (!aresetn) stats_valid_out |-> stats_vector_out[0] != stats_vector_out[3];
  endproperty
  a_ok_bit: assert property (p_ok_bit) else $error("ok bit disagrees with error");

  property p_len_cap;
    @(posedge aclk) disable iff (!aresetn) stats_vector_out[18:5] <= EMTX_LEN_MAX;
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("length above cap");

  property p_error_forward;
    @(posedge aclk) disable iff (!aresetn) (take && cur.error) |=> phy_error_out && phy_valid_out;
  endproperty
  a_error_forward: assert property (p_error_forward) else $error("error not sent to phy");

  property p_gap_holds;
    @(posedge aclk) disable iff (!aresetn) (state_reg == EMTX_GAP) |-> !stream_ready_out && !av_stream_ready_out;
  endproperty
  a_gap_holds: assert property (p_gap_holds) else $error("ready during gap");

  property p_pace_100m;
    @(posedge aclk) disable iff (!aresetn)
      (stream_ready_out && pace_len == EMTX_PACE_100M) |=> !stream_ready_out [*8];
  endproperty
  a_pace_100m: assert property (p_pace_100m) else $error("ready faster than line rate");

  property p_retx_with_coll;
    @(posedge aclk) disable iff (!aresetn) retransmit_out |-> collision_out;
  endproperty
  a_retx_with_coll: assert property (p_retx_with_coll) else $error("retransmit without collision");

  property p_ready_one_stream;
    @(posedge aclk) disable iff (!aresetn) !(stream_ready_out && av_stream_ready_out);
  endproperty
  a_ready_one_stream: assert property (p_ready_one_stream) else $error("both streams ready");

  c_frame_end: cover property (@(posedge aclk) disable iff (!aresetn) stats_valid_out);
  c_collision: cover property (@(posedge aclk) disable iff (!aresetn) collision_out && retransmit_out);
  c_av_take: cover property (@(posedge aclk) disable iff (!aresetn) take && av_sel_reg);
  c_gap: cover property (@(posedge aclk) disable iff (!aresetn) state_reg == EMTX_GAP);

endmodule

// ==== tb/emtx_frame_src.sv ====
// emtx_frame_src: client model that feeds one byte stream of the port
// assumes: one clock, sync active-low reset, bench pulses go with len/err/base
`timescale 1ns/1ps

module emtx_frame_src
  import emtx_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command from the bench
  input wire logic go,
  input wire logic [13:0] len,
  input wire logic err,
  input wire logic [7:0] base,
  // stream toward the port
  output emtx_stream_t strm,
  input wire logic ready,
  input wire logic abort
);
  import emtx_pkg::*;

  logic [13:0] idx_reg;

  // ----------------------------------------------------------------
  // byte k of a frame is base xor k, all levels but aresetn active high
  // ----------------------------------------------------------------
  // idle data toggles so a stale byte can never look valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strm <= '{data: 8'h5A, valid: 1'b0, last: 1'b0, error: 1'b0};
      idx_reg <= 14'h0000;
    end else if (abort && strm.valid) begin
      strm.valid <= 1'b0;
      strm.last <= 1'b0;
      strm.data <= ~strm.data;
    end else if (go) begin
      strm.valid <= 1'b1;
      strm.data <= base;
      strm.last <= (len == 14'h0001);
      strm.error <= err;
      idx_reg <= 14'h0001;
    end else if (strm.valid && ready) begin
      if (strm.last) begin
        strm.valid <= 1'b0;
        strm.last <= 1'b0;
        strm.data <= ~strm.data;
      end else begin
        strm.data <= base ^ idx_reg[7:0];
        strm.last <= (idx_reg == len - 14'h0001);
        idx_reg <= idx_reg + 14'h0001;
      end
    end else if (!strm.valid) begin
      strm.data <= ~strm.data;
    end
  end
endmodule

// ==== tb/emtx_client_port_tb.sv ====
// emtx_client_port_tb: sequence tests of the transmit client port
// assumes: client models on both streams, bench drives AXI4-Lite and sideband
`timescale 1ns/1ps

module emtx_client_port_tb;
  import emtx_pkg::*;

  logic aclk, aresetn, go_m, go_a, err, mc, awvalid, wvalid, bready, arvalid, rready;
  logic [13:0] len, cnt;
  logic [7:0] base, ifg, phy_byte_out;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, stats_vector_out, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stream_ready_out, av_stream_ready_out, collision_out, retransmit_out, stats_valid_out;
  logic phy_valid_out, phy_error_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic first_pend, err_seen, coll_seen;
  emtx_stream_t sm, sa;
  int fail_count, cmp_count, cyc, prev_rdy, ivl, ivl_first, k;

  emtx_client_port #(.PFC_EN(1'b0), .AV_EN(1'b1)) emtx_client_port_i (
    .aclk(aclk), .aresetn(aresetn),
    .stream_byte_in(sm.data), .stream_valid_in(sm.valid), .stream_last_in(sm.last),
    .stream_error_in(sm.error), .stream_ready_out(stream_ready_out),
    .av_stream_byte_in(sa.data), .av_stream_valid_in(sa.valid), .av_stream_last_in(sa.last),
    .av_stream_error_in(sa.error), .av_stream_ready_out(av_stream_ready_out),
    .ifg_delay_in(ifg), .medium_collision_in(mc), .collision_out(collision_out),
    .retransmit_out(retransmit_out), .stats_vector_out(stats_vector_out), .stats_valid_out(stats_valid_out),
    .phy_byte_out(phy_byte_out), .phy_valid_out(phy_valid_out), .phy_error_out(phy_error_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready));

  emtx_frame_src emtx_frame_src_i (.aclk(aclk), .aresetn(aresetn), .go(go_m), .len(len), .err(err),
    .base(base), .strm(sm), .ready(stream_ready_out), .abort(collision_out));
  emtx_frame_src emtx_frame_src_av_i (.aclk(aclk), .aresetn(aresetn), .go(go_a), .len(len), .err(err),
    .base(base), .strm(sa), .ready(av_stream_ready_out), .abort(collision_out));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // a wait that runs out counts as a mismatch and ends the run
  task bail;
    fail_count++;
    stop_test;
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && s_axi_awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && s_axi_wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid === 1'b1 && aw && w) && k < 200);
    bready <= 1'b0;
    if (k >= 200) bail;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    // let an edge pass so the next call does not re-drive bready in this step
    @(posedge aclk);
  endtask

  task axi_rd(input logic [3:0] a, input logic [31:0] e);
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && s_axi_arready === 1'b1) arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    rready <= 1'b0;
    if (k >= 200) bail;
    chk("rdata", e, s_axi_rdata);
    @(posedge aclk);
  endtask

  task send(input logic [13:0] n, input logic e, input logic av, input logic [7:0] b);
    len <= n;
    err <= e;
    base <= b;
    go_m <= !av;
    go_a <= av;
    @(posedge aclk);
    go_m <= 1'b0;
    go_a <= 1'b0;
  endtask

  task wait_stats(input logic [13:0] n, input logic ok, input logic [3:0] t);
    k = 0;
    while (stats_valid_out !== 1'b1 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 3000) bail;
    // one more edge so the monitor has counted the last phy byte
    @(posedge aclk);
    chk("st_len", {18'h0, n}, {18'h0, stats_vector_out[18:5]});
    chk("st_ok", {31'h0, ok}, {31'h0, stats_vector_out[0]});
    chk("st_try", {28'h0, t}, {28'h0, stats_vector_out[28:25]});
    chk("st_cnt", {18'h0, n}, {18'h0, cnt});
  endtask

  // ----------------------------------------------------------------
  // clock, output monitor and main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // checks byte order on the phy side and times the ready pulses
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (go_m || go_a) begin
      cnt <= 14'h0000;
      err_seen <= 1'b0;
      coll_seen <= 1'b0;
      first_pend <= 1'b1;
    end else begin
      if (phy_valid_out === 1'b1) begin
        chk("phy_byte", {24'h0, base ^ cnt[7:0]}, {24'h0, phy_byte_out});
        cnt <= cnt + 14'h0001;
        if (phy_error_out === 1'b1) err_seen <= 1'b1;
      end
      if (collision_out === 1'b1 || retransmit_out === 1'b1) coll_seen <= 1'b1;
    end
    if (stream_ready_out === 1'b1 || av_stream_ready_out === 1'b1) begin
      ivl <= cyc - prev_rdy;
      prev_rdy <= cyc;
      if (first_pend) ivl_first <= cyc - prev_rdy;
      first_pend <= 1'b0;
    end
  end

  initial begin
    {aresetn, go_m, go_a, err, mc, awvalid, wvalid, bready, arvalid, rready} = '0;
    {len, base, ifg, awaddr, araddr, wdata} = '0;
    {fail_count, cmp_count, cyc, prev_rdy, ivl, ivl_first} = '0;
    cnt = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("idle_out", 32'h0, {27'h0, stats_valid_out, stream_ready_out, collision_out, retransmit_out, phy_valid_out});
    axi_rd(EMTX_ADDR_CTRL, EMTX_CTRL_RESET);
    axi_rd(EMTX_ADDR_IFG, {24'h0, EMTX_IFG_RESET});
    axi_wr(EMTX_ADDR_STATUS, 32'h0000_0001, 2'b10);
    // one frame at each speed, ready spacing set by line rate
    for (int s = 0; s < 3; s++) begin
      axi_wr(EMTX_ADDR_CTRL, s, 2'b00);
      send(14'h0003, 1'b0, 1'b0, 8'h10);
      wait_stats(14'h0003, 1'b1, 4'h0);
      chk("ready_gap", {24'h0, s == 0 ? EMTX_PACE_10M : s == 1 ? EMTX_PACE_100M : EMTX_PACE_1G}, ivl);
    end
    // underrun marked frame at 1G
    send(14'h0004, 1'b1, 1'b0, 8'h40);
    wait_stats(14'h0004, 1'b0, 4'h0);
    chk("st_under", 32'h1, {31'h0, stats_vector_out[EMTX_ST_UNDERRUN_BIT]});
    chk("phy_err", 32'h1, {31'h0, err_seen});
    // wider gap between back-to-back frames
    ifg <= 8'h14;
    @(posedge aclk);
    axi_rd(EMTX_ADDR_IFG, 32'h0000_0014);
    send(14'h0002, 1'b0, 1'b0, 8'h50);
    wait_stats(14'h0002, 1'b1, 4'h0);
    send(14'h0002, 1'b0, 1'b0, 8'h60);
    wait_stats(14'h0002, 1'b1, 4'h0);
    chk("ifg_wait", 32'h1, {31'h0, ivl_first > 20 && ivl_first <= 28});
    // full duplex ignores a medium collision
    send(14'h0006, 1'b0, 1'b0, 8'h20);
    mc <= 1'b1;
    repeat (4) @(posedge aclk);
    mc <= 1'b0;
    wait_stats(14'h0006, 1'b1, 4'h0);
    chk("coll_fd", 32'h0, {31'h0, coll_seen});
    // half duplex: collision aborts, frame is resent
    axi_wr(EMTX_ADDR_CTRL, 32'h0000_0006, 2'b00);
    send(14'h001E, 1'b0, 1'b0, 8'h30);
    repeat (4) @(posedge aclk);
    mc <= 1'b1;
    k = 0;
    while (collision_out !== 1'b1 && k < 50) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 50) bail;
    chk("retx", 32'h1, {31'h0, retransmit_out});
    mc <= 1'b0;
    repeat (40) @(posedge aclk);
    send(14'h001E, 1'b0, 1'b0, 8'h30);
    wait_stats(14'h001E, 1'b1, 4'h1);
    // av stream paced at 100 Mb/s
    axi_wr(EMTX_ADDR_CTRL, 32'h0000_0009, 2'b00);
    send(14'h0003, 1'b0, 1'b1, 8'h80);
    wait_stats(14'h0003, 1'b1, 4'h0);
    chk("av_gap", {24'h0, EMTX_PACE_100M}, ivl);
    axi_rd(EMTX_ADDR_STATS, 32'h0000_0061);
    stop_test;
  end
endmodule
